// *** rtl/sdl_synth_core.sv ***
/*
 * Digital part of the synthesizer loop: reference divider, pulse-swallow feedback
 * divider with serially loaded ratio, phase/frequency detector, lock and transmit gate.
 * Assumes the host drives the three-wire port slowly against the 20 MHz clock and the
 * feedback input is already brought below half that rate by the front end.
 */
// Overview of operation
// RQ1: Divide reference by 2640 to 5 kHz
// RQ2: Prescale feedback before the programmable stage
// RQ3: Programmable divider brings feedback to 5 kHz
// RQ4: Compare feedback and reference phase each period
// RQ5: Ratio LSB step equals one 5 kHz step
// RQ6: Transmit enable is lock AND key request
// RQ7: Host shifts division word in serially
// RQ8: Bits shift on clock; enable latches word
// RQ9: Old ratio kept; unlock after new ratio
module sdl_synth_core
	import sdl_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// Loop pins
	input wire logic ref_osc_i,
	input wire logic vco_fb_i,
	// Host side
	input sdl_pkg::sdl_serial_t ser_i,
	input wire logic transmit_key_request_i,
	// Outputs
	output logic pump_up_o,
	output logic pump_dn_o,
	output logic lock_o,
	output logic tx_enable_o
);
	import sdl_pkg::*;

	function automatic logic [3:0] sat_inc4(input logic [3:0] v, input logic [3:0] lim);
		sat_inc4 = (v >= lim) ? lim : v + 4'h1;
	endfunction

	// ****************************************
	// Input synchronisers
	// ****************************************
	// Bits: 5 key, 4 load enable, 3 sclk, 2 sdata, 1 feedback, 0 reference
	logic [5:0] raw, sync1, sync2, sync3, next_sync1, next_sync2, next_sync3;
	logic [5:0] rise;

	assign raw = {transmit_key_request_i, ser_i.load_en, ser_i.sclk, ser_i.sdata, vco_fb_i, ref_osc_i};
	assign rise = sync2 & ~sync3;

	always_comb begin
		next_sync1 = raw;
		next_sync2 = sync1;
		next_sync3 = sync2;
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync1 <= 6'h00;
			sync2 <= 6'h00;
			sync3 <= 6'h00;
		end else begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
			sync3 <= next_sync3;
		end
	end

	// ****************************************
	// Serial load
	// ****************************************
	// Shifting never disturbs the running ratio; only the enable edge replaces it
	logic [RATIO_W-1:0] shift, ratio, next_shift, next_ratio;
	logic latch;

	assign latch = rise[4];

	always_comb begin
		next_shift = shift;
		next_ratio = ratio;
		if (rise[3])
			next_shift = {shift[RATIO_W-2:0], sync2[2]}; // RQ8
		if (latch)
			next_ratio = shift; // RQ8
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			shift <= '0;
			ratio <= RATIO_RST;
		end else begin
			shift <= next_shift;
			ratio <= next_ratio;
		end
	end

	// ****************************************
	// Reference divider
	// ****************************************
	logic [11:0] ref_cnt, next_ref_cnt;
	logic ref_tick;

	assign ref_tick = rise[0] && (ref_cnt == REF_LAST); // RQ1

	always_comb begin
		next_ref_cnt = ref_cnt;
		if (ref_tick)
			next_ref_cnt = 12'h000; // RQ1
		else if (rise[0])
			next_ref_cnt = ref_cnt + 12'h001;
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i)
			ref_cnt <= 12'h000;
		else
			ref_cnt <= next_ref_cnt;
	end

	// ****************************************
	// Feedback divider
	// ****************************************
	// Total ratio = M*P + A, so one step of the low bits moves the lock point by one
	// comparison step; M must be at least A and at least one for this to hold.
	logic [4:0] pre_cnt, next_pre_cnt, pre_last;
	logic [MAIN_W-1:0] main_cnt, next_main_cnt;
	logic [SWAL_W-1:0] swal_cnt, next_swal_cnt;
	logic pre_tick, fb_tick;

	assign pre_last = (swal_cnt != '0) ? PRE_MOD : PRE_MOD - 5'h01; // RQ5
	assign pre_tick = rise[1] && (pre_cnt == pre_last); // RQ2
	// Compare with >= so a smaller ratio loaded mid-count wraps at the next prescaler tick instead of running the counter round
	assign fb_tick = pre_tick && (main_cnt >= ratio[RATIO_W-1:SWAL_W] - 14'h0001); // RQ3

	always_comb begin
		next_pre_cnt = pre_cnt;
		next_main_cnt = main_cnt;
		next_swal_cnt = swal_cnt;
		if (pre_tick)
			next_pre_cnt = 5'h00;
		else if (rise[1])
			next_pre_cnt = pre_cnt + 5'h01; // RQ2
		if (fb_tick) begin
			next_main_cnt = '0;
			next_swal_cnt = ratio[SWAL_W-1:0]; // RQ5
		end else if (pre_tick) begin
			next_main_cnt = main_cnt + 14'h0001; // RQ3
			if (swal_cnt != '0)
				next_swal_cnt = swal_cnt - 4'h1;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pre_cnt <= 5'h00;
			main_cnt <= '0;
			swal_cnt <= '0;
		end else begin
			pre_cnt <= next_pre_cnt;
			main_cnt <= next_main_cnt;
			swal_cnt <= next_swal_cnt;
		end
	end

	// ****************************************
	// Phase detector and lock
	// ****************************************
	sdl_pfd_t pfd, next_pfd;
	logic [7:0] err_cnt, next_err_cnt;
	logic [3:0] good_cnt, next_good_cnt;
	logic next_pump_up, next_pump_dn, next_lock, next_tx;
	logic done;

	always_comb begin
		next_pfd = pfd;
		next_err_cnt = err_cnt;
		next_good_cnt = good_cnt;
		done = 1'b0;
		case (pfd)
			PFD_IDLE: begin
				next_err_cnt = 8'h00;
				if (ref_tick && fb_tick)
					done = 1'b1;
				else if (ref_tick)
					next_pfd = PFD_UP; // RQ4
				else if (fb_tick)
					next_pfd = PFD_DN; // RQ4
			end
			PFD_UP, PFD_DN: begin
				if ((pfd == PFD_UP && fb_tick) || (pfd == PFD_DN && ref_tick)) begin
					next_pfd = PFD_IDLE;
					done = 1'b1;
				end else if (err_cnt != 8'hff) begin
					next_err_cnt = err_cnt + 8'h01;
				end
			end
			default: next_pfd = PFD_IDLE;
		endcase
		if (latch)
			next_good_cnt = 4'h0; // RQ9
		else if (done)
			next_good_cnt = (err_cnt <= LOCK_WIN) ? sat_inc4(good_cnt, LOCK_CNT) : 4'h0;
		next_lock = !latch && (next_good_cnt == LOCK_CNT); // RQ9
		next_pump_up = (next_pfd == PFD_UP);
		next_pump_dn = (next_pfd == PFD_DN);
		next_tx = lock_o && sync2[5]; // RQ6
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pfd <= PFD_IDLE;
			err_cnt <= 8'h00;
			good_cnt <= 4'h0;
			lock_o <= 1'b0;
			pump_up_o <= 1'b0;
			pump_dn_o <= 1'b0;
			tx_enable_o <= 1'b0;
		end else begin
			pfd <= next_pfd;
			err_cnt <= next_err_cnt;
			good_cnt <= next_good_cnt;
			lock_o <= next_lock;
			pump_up_o <= next_pump_up;
			pump_dn_o <= next_pump_dn;
			tx_enable_o <= next_tx;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	// Feedback edges per wrap, counted apart from the divider; only periods run wholly on one ratio are judged
	logic [RATIO_W-1:0] fb_edges, next_fb_edges;
	logic ratio_steady, next_ratio_steady;

	always_comb begin
		next_fb_edges = fb_edges;
		next_ratio_steady = ratio_steady && !latch;
		if (fb_tick) begin
			next_fb_edges = '0;
			next_ratio_steady = !latch;
		end else if (rise[1]) begin
			next_fb_edges = fb_edges + 18'h0_0001;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fb_edges <= '0;
			ratio_steady <= 1'b0;
		end else begin
			fb_edges <= next_fb_edges;
			ratio_steady <= next_ratio_steady;
		end
	end

	ref_wrap_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ1
		ref_tick |=> ref_cnt == 12'h000) else $error("reference divider did not wrap");
	ref_count_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ1
		rise[0] && !ref_tick |=> ref_cnt == $past(ref_cnt) + 12'h001) else $error("reference count wrong");
	pre_modulus_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ2
		pre_tick |-> pre_cnt == ((swal_cnt != '0) ? 5'h10 : 5'h0f)) else $error("prescaler modulus wrong");
	fb_reload_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ3
		fb_tick && !latch |=> main_cnt == '0 && swal_cnt == ratio[3:0]) else $error("feedback divider reload wrong");
	pump_exclusive_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ4
		!(pump_up_o && pump_dn_o)) else $error("both pump outputs active");
	pump_up_start_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ4
		pfd == PFD_IDLE && ref_tick && !fb_tick |=> pump_up_o) else $error("pump up missing");
	pump_dn_start_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ4
		pfd == PFD_IDLE && fb_tick && !ref_tick |=> pump_dn_o) else $error("pump down missing");
	fb_total_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ5
		fb_tick && ratio_steady |-> fb_edges + 18'h0_0001 ==
		{ratio[RATIO_W-1:SWAL_W], 4'h0} + {{MAIN_W{1'b0}}, ratio[SWAL_W-1:0]}) else $error("feedback ratio wrong");
	tx_gate_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ6
		tx_enable_o == ($past(lock_o) && $past(sync2[5]))) else $error("transmit enable not lock and key");
	shift_in_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ8
		rise[3] |=> shift[0] == $past(sync2[2])) else $error("serial bit not shifted");
	ratio_hold_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ9
		!latch |=> $stable(ratio)) else $error("ratio changed without load enable");
	unlock_load_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ9
		latch |=> !lock_o ##1 !lock_o) else $error("lock held after new ratio");

endmodule // sdl_synth_core

// *** rtl/sdl_pkg.sv ***
/*
 * Shared constants and types for the synthesizer divider with serial ratio load.
 * Assumes a single 20 MHz system clock and that all pin inputs are asynchronous to it.
 */
package sdl_pkg;

	// ****************************************
	// Clock and frequency plan
	// ****************************************
	localparam int CLK_NS = 50;
	localparam int REF_HZ = 13_200_000;
	localparam int CMP_HZ = 5_000;
	localparam logic [11:0] REF_LAST = 12'(REF_HZ / CMP_HZ - 1);

	// ****************************************
	// Feedback prescaler (dual modulus P / P+1)
	// ****************************************
	localparam logic [4:0] PRE_MOD = 5'h1_0;
	localparam int RATIO_W = 18;
	localparam int SWAL_W = 4;
	localparam int MAIN_W = RATIO_W - SWAL_W;
	localparam logic [RATIO_W-1:0] RATIO_RST = 18'h0_2000;

	// ****************************************
	// Lock detection
	// ****************************************
	localparam int LOCK_WIN_NS = 500;
	localparam logic [7:0] LOCK_WIN = 8'(LOCK_WIN_NS / CLK_NS);
	localparam logic [3:0] LOCK_CNT = 4'h8;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic load_en;
		logic sclk;
		logic sdata;
	} sdl_serial_t;

	typedef enum logic [1:0] {
		PFD_IDLE,
		PFD_UP,
		PFD_DN
	} sdl_pfd_t;

endpackage

// *** bench/sdl_host_model.sv ***
/*
 * Host model that loads the divider word over the three-wire port.
 * Assumes it is the only driver of ser_o and is called just after a falling edge of mclk_i.
 */
module sdl_host_model
	import sdl_pkg::*;
(
	// Clock
	input wire logic mclk_i,
	// Serial port
	output sdl_pkg::sdl_serial_t ser_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		ser_o = '0;
	end

	// Each level is held 3 cycles, one above the 2-cycle minimum
	task automatic hold3();
		repeat (3) @(negedge mclk_i);
	endtask

	// Pad bits go ahead of the word so that only the last 18 bits count
	task automatic shift_word(input logic [RATIO_W-1:0] word, input logic [3:0] pad, input int npad);
		logic [RATIO_W+3:0] bits;
		bits = {pad, word};
		for (int i = RATIO_W + npad - 1; i >= 0; i--) begin
			ser_o.sdata <= bits[i];
			hold3();
			ser_o.sclk <= 1'b1;
			hold3();
			ser_o.sclk <= 1'b0;
		end
		// Released data line shows the inverse, never a stale copy
		ser_o.sdata <= ~bits[0];
	endtask

	task automatic pulse_load();
		hold3();
		ser_o.load_en <= 1'b1;
		hold3();
		ser_o.load_en <= 1'b0;
	endtask
endmodule // sdl_host_model

// *** bench/tb_synth_divider_serial_load.sv ***
/*
 * Self-checking bench for the synthesizer divider: host model, loop stand-in, checks.
 * Assumes inputs change on the falling edge and the design's reset values from the package.
 */
module tb_synth_divider_serial_load
	import sdl_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;

	// 1320 edges at the nominal 4-cycle feedback period match 2640 reference edges at 2 cycles
	localparam logic [RATIO_W-1:0] LOCK_WORD = 18'h0_0528;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic ref_osc = 1'b0;
	logic vco_fb = 1'b0;
	logic key = 1'b0;
	logic pump_up, pump_dn, lock, tx_en, lock_d;
	logic [1:0] fb_cnt = 2'h0;
	logic [4:0] key_hist = 5'h00;
	sdl_serial_t ser;
	logic exp_q[$];
	int mismatches = 0;
	int check_count = 0;

	sdl_host_model host (.mclk_i(mclk), .ser_o(ser));
	sdl_synth_core dut (.mclk_i(mclk), .resetn_i(resetn), .ref_osc_i(ref_osc), .vco_fb_i(vco_fb), .ser_i(ser),
		.transmit_key_request_i(key), .pump_up_o(pump_up), .pump_dn_o(pump_dn), .lock_o(lock), .tx_enable_o(tx_en));

	initial begin
		forever #25 mclk = ~mclk;
	end

	task automatic check_bit(input string what, input logic exp, input logic got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ****************************************
	// Loop stand-in
	// ****************************************
	// Feedback period 4 cycles, 2 on pump up, held on pump down: a crude oscillator
	always @(negedge mclk) begin
		ref_osc <= ~ref_osc;
		if (!pump_dn) begin
			fb_cnt <= (fb_cnt >= (pump_up ? 2'h1 : 2'h3)) ? 2'h0 : fb_cnt + 2'h1;
			vco_fb <= (fb_cnt == 2'h0);
		end
	end

	// ****************************************
	// Output watchers
	// ****************************************
	always @(lock) begin
		if (resetn) begin
			check_bit("lock_o", exp_q.size() > 0 ? exp_q.pop_front() : ~lock, lock);
		end
	end

	// Transmit gate judged only once the key has settled through its synchronizer
	always @(negedge mclk) begin
		key_hist <= {key_hist[3:0], key};
		lock_d <= lock;
		if (resetn) begin
			check_bit("pump pair", 1'b0, pump_up & pump_dn);
			if (key_hist == 5'h1f || key_hist == 5'h00) begin
				check_bit("tx_enable_o", lock_d & key_hist[0], tx_en);
			end
		end
	end

	initial begin
		wait (resetn);
		forever begin
			repeat ($urandom_range(83, 20)) @(negedge mclk);
			key <= 1'($urandom);
		end
	end

	// Locking on the loaded LOCK_WORD takes under 90k cycles, inside this 100k-cycle limit
	initial begin
		repeat (100000) @(posedge mclk);
		mismatches++;
		wrap_up();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [3:0] pad;
		int npad;
		void'($urandom(32'h5d33a851));
		pad = 4'($urandom);
		npad = $urandom_range(4, 0);
		repeat (10) @(negedge mclk);
		check_bit("reset outputs", 1'b0, pump_up | pump_dn | lock | tx_en);
		resetn <= 1'b1;
		exp_q.push_back(1'b1);
		host.shift_word(LOCK_WORD, pad, npad);
		host.pulse_load();
		for (int i = 0; i < 90000 && lock !== 1'b1; i++) begin
			@(negedge mclk);
		end
		check_bit("lock reached", 1'b1, lock);
		// One LSB up: the old ratio must hold until the load strobe
		host.shift_word(LOCK_WORD + 18'h0_0001, ~pad, npad);
		check_bit("lock_o while shifting", 1'b1, lock);
		exp_q.push_back(1'b0);
		host.pulse_load();
		repeat (6) @(negedge mclk);
		check_bit("lock_o after load", 1'b0, lock);
		check_bit("tx_enable_o after load", 1'b0, tx_en);
		check_bit("pending lock changes", 1'b1, exp_q.size() == 0);
		wrap_up();
	end
endmodule // tb_synth_divider_serial_load
